//--- design/ksc_call_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module ksc_call_ctrl #(
   parameter int TICK_CYC_P = ksc_pkg::TICK_CYC
) (
   input  wire logic                      clk_sys,
   input  wire logic                      rst,
   input  wire logic [ksc_pkg::NT-1:0]    terminal_loop_detect,
   input  wire logic [ksc_pkg::NL-1:0]    line_ring_detect,
   input  wire logic [ksc_pkg::NL-1:0]    line_loop_detect,
   input  wire logic [3:0]                button_code,
   input  wire logic                      night_service,
   output logic      [2:0]                scan_select,
   output logic      [ksc_pkg::NT-1:0]    relay_select_a,
   output logic      [ksc_pkg::NT-1:0]    relay_select_b,
   output logic      [ksc_pkg::NL-1:0]    line_hold_relay,
   output logic      [2*ksc_pkg::NT-1:0]  line_lamp,
   output logic                           dec_data,
   output logic                           dec_clk,
   output logic                           dec_latch
);
   import ksc_pkg::*;

   typedef struct packed {
      ksc_term_t [NT-1:0]          ts;
      logic [NT-1:0]               tl;
      logic [NT-1:0][TC_W-1:0]     tc;
      logic [NT-1:0][3:0]          pb;
      logic [NT-1:0][NL-1:0]       prog;
      logic [NT-1:0]               dv;
      logic [NT-1:0]               fa;
      logic [NL-1:0]               hold;
      logic [NL-1:0]               relp;
      logic [NL-1:0]               xa;
      logic [NL-1:0][2:0]          hdr;
      logic [NL-1:0][2:0]          xto;
      logic [2:0]                  si;
      logic [SC_W-1:0]             sc;
      logic [DIV_W-1:0]            dc;
      logic                        tick;
      logic [TC_W-1:0]             cad;
      logic [NT-1:0]               ra;
      logic [NT-1:0]               rb;
      logic [2*NT-1:0]             lamp;
   } ksc_state_t;

   ksc_state_t s_reg, s_next;

   // first terminal of a line group, wired to its line when unpowered
   function automatic logic [2:0] first_of(input logic l);
      return l ? 3'h3 : 3'h0;
   endfunction : first_of

   // first terminal of a group: both relays energised is intercom and
   // both released is its own line, so a dead controller leaves it there
   function automatic logic [1:0] first_sense(input logic [1:0] c,
                                              input logic       second);
      logic [1:0] own;
      own = second ? RLY_L2 : RLY_L1;
      if (c == own) begin
         return 2'h0;
      end else if (c == RLY_L2) begin
         return ~own;
      end else begin
         return ~c;
      end
   endfunction : first_sense

   logic [2:0]      t;
   logic            lp;
   logic            scan_en;
   logic            press;
   logic            is_line;
   logic            is_ext;
   logic            bl;
   logic [2:0]      tgt;
   logic            slow;
   logic            fast;
   logic [NL-1:0]   busy;
   logic [NL-1:0]   ring_act;
   logic [NL-1:0]   div_l;
   logic [NL-1:0]   all_l;
   logic [NT-1:0]   free_t;
   logic [NT-1:0]   want_x;
   logic [FRAME_BITS-1:0] frame;

   // scan decode: code belongs to the terminal on scan_select
   assign t       = s_reg.si;
   assign lp      = terminal_loop_detect[t];
   assign scan_en = (s_reg.sc == SCAN_LAST);
   assign press   = scan_en && lp && button_code != BTN_NONE &&
                    s_reg.pb[t] == BTN_NONE;
   assign is_line = button_code == BTN_LINE1 || button_code == BTN_LINE2;
   assign is_ext  = button_code >= BTN_EXT1 && button_code <= BTN_EXT6;
   assign bl      = button_code[0];
   assign tgt     = button_code[2:0] - 3'h1;
   // cadence phases from the tick counter
   assign slow    = s_reg.cad < RING_HALF;
   assign fast    = (s_reg.cad < FAST_HALF) ||
                    (s_reg.cad >= RING_HALF &&
                     s_reg.cad < RING_HALF + FAST_HALF);

   // exchange ringing targets; divert moves a terminal's ringing to
   // terminal 1 (index 0) rather than dropping the call
   always_comb begin
      busy   = s_reg.hold;
      div_l  = '0;
      all_l  = '0;
      want_x = '0;
      for (int i = 0; i < NT; i++) begin
         free_t[i] = s_reg.ts[i] == T_IDLE && !terminal_loop_detect[i];
      end
      for (int l = 0; l < NL; l++) begin
         for (int i = 0; i < NT; i++) begin
            if ((s_reg.ts[i] == T_EXCH || s_reg.ts[i] == T_REL) &&
                s_reg.tl[i] == l[0]) begin
               busy[l] = 1'b1;
            end
            if (s_reg.dv[i] && s_reg.prog[i][l]) begin
               div_l[l] = 1'b1;
            end
         end
         ring_act[l] = line_ring_detect[l] && !busy[l];
         all_l[l] = !free_t[first_of(l[0])];
         for (int i = 0; i < NT; i++) begin
            if (free_t[i] && s_reg.prog[i][l] && !s_reg.dv[i]) begin
               all_l[l] = 1'b0;
            end
         end
      end
      for (int i = 0; i < NT; i++) begin
         for (int l = 0; l < NL; l++) begin
            if (free_t[i] && ring_act[l] &&
                ((s_reg.prog[i][l] && !s_reg.dv[i]) ||
                 (i == 0 && div_l[l]) ||
                 all_l[l])) begin
               want_x[i] = 1'b1;
            end
         end
      end
   end

   // main next-state logic: timers, scan step, relay and lamp images
   always_comb begin
      logic [1:0] code;
      logic       hl;
      code = RLY_ICM;
      hl = 1'b0;
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (s_reg.dc == DIV_W'(TICK_CYC_P - 1)) begin
         s_next.dc = '0;
         s_next.tick = 1'b1;
      end else begin
         s_next.dc = s_reg.dc + 1'b1;
      end
      if (s_reg.tick) begin
         s_next.cad = (s_reg.cad == 2 * RING_HALF - 1) ?
                      '0 : s_reg.cad + 1'b1;
      end
      for (int i = 0; i < NT; i++) begin
         if (s_reg.tick && s_reg.tc[i] != '1 &&
             (s_reg.ts[i] == T_REL || s_reg.ts[i] == T_RBACK)) begin
            s_next.tc[i] = s_reg.tc[i] + 1'b1;
         end
      end
      s_next.sc = scan_en ? '0 : s_reg.sc + 1'b1;
      if (scan_en) begin
         s_next.si = (s_reg.si == LAST_TERM) ? '0 : s_reg.si + 3'h1;
         s_next.pb[t] = lp ? button_code : BTN_NONE;
         // hold drops one scan after the line has been taken over
         for (int l = 0; l < NL; l++) begin
            if (s_reg.relp[l] ||
                (s_reg.hold[l] && !line_loop_detect[l])) begin
               s_next.hold[l] = 1'b0;
               s_next.relp[l] = 1'b0;
               s_next.xa[l]   = 1'b0;
            end
         end
         hl = s_reg.tl[t];
         // loop-detect watch of the scanned terminal
         case (s_reg.ts[t])
            T_RINGI: begin
               if (lp) begin
                  s_next.ts[t] = T_IDLE;
               end
            end
            T_EXCH: begin
               if (!lp) begin
                  s_next.ts[t] = T_REL;
                  s_next.tc[t] = '0;
               end
            end
            T_REL: begin
               if (lp) begin
                  s_next.ts[t] = T_EXCH;
               end else if (s_reg.tc[t] >= REL_TICKS) begin
                  s_next.ts[t] = T_IDLE;
               end
            end
            T_HOLD: begin
               if (!lp) begin
                  if (s_reg.xa[hl] && s_reg.hdr[hl] == t) begin
                     s_next.ts[s_reg.xto[hl]] = T_EXCH;
                     s_next.tl[s_reg.xto[hl]] = hl;
                     s_next.relp[hl] = 1'b1;
                     s_next.ts[t] = T_IDLE;
                  end else if (s_reg.hold[hl] &&
                               line_loop_detect[hl]) begin
                     s_next.ts[t] = T_RBACK;
                     s_next.tc[t] = '0;
                  end else begin
                     s_next.ts[t] = T_IDLE;
                  end
               end
            end
            T_RBACK: begin
               if (lp) begin
                  s_next.ts[t] = T_EXCH;
                  s_next.relp[hl] = 1'b1;
               end else if (!s_reg.hold[hl]) begin
                  s_next.ts[t] = T_IDLE;
               end
            end
            default: begin
            end
         endcase
      end
      // button press of the scanned terminal
      if (press) begin
         if (button_code == BTN_FAC) begin
            s_next.fa[t] = !s_reg.fa[t];
            if (s_reg.fa[t]) begin
               s_next.prog[t] = '0;
            end
         end else if (s_reg.fa[t]) begin
            s_next.fa[t] = 1'b0;
            if (is_line) begin
               s_next.prog[t][bl] = 1'b1;
            end else if (button_code == BTN_EXT1) begin
               s_next.dv[t] = 1'b1;
            end else if (button_code == BTN_EXT2) begin
               s_next.dv[t] = 1'b0;
            end
         end else if (is_line) begin
            if (s_reg.ts[t] == T_EXCH && s_reg.tl[t] == bl &&
                line_loop_detect[bl]) begin
               s_next.hold[bl] = 1'b1;
               s_next.hdr[bl]  = t;
               s_next.ts[t]    = T_HOLD;
            end else if (s_reg.ts[t] == T_HOLD && s_reg.hold[bl] &&
                         s_reg.hdr[bl] == t &&
                         line_loop_detect[bl]) begin
               s_next.ts[t]    = T_EXCH;
               s_next.tl[t]    = bl;
               s_next.relp[bl] = 1'b1;
            end else if (s_reg.xa[bl] && s_reg.xto[bl] == t) begin
               s_next.ts[t]    = T_EXCH;
               s_next.tl[t]    = bl;
               s_next.relp[bl] = 1'b1;
               s_next.ts[s_reg.hdr[bl]] = T_IDLE;
            end else if (s_reg.ts[t] == T_IDLE && !busy[bl]) begin
               s_next.ts[t] = T_EXCH;
               s_next.tl[t] = bl;
            end
         end else if (is_ext && tgt != t) begin
            if (s_reg.ts[t] == T_EXCH && !s_reg.hold[hl] &&
                line_loop_detect[hl]) begin
               s_next.hold[hl] = 1'b1;
               s_next.hdr[hl]  = t;
               s_next.xa[hl]   = 1'b1;
               s_next.xto[hl]  = tgt;
               s_next.ts[t]    = T_HOLD;
            end
            if (s_reg.ts[tgt] == T_IDLE &&
                !terminal_loop_detect[tgt]) begin
               s_next.ts[tgt] = T_RINGI;
            end
         end
      end
      // relay and lamp images, registered
      for (int i = 0; i < NT; i++) begin
         case (s_reg.ts[i])
            T_RINGI: code = slow ? RLY_RING : RLY_ICM;
            T_EXCH, T_REL: code = s_reg.tl[i] ? RLY_L2 : RLY_L1;
            T_RBACK: code = (s_reg.tc[i] >= RB_TICKS && fast) ?
                            RLY_RING : RLY_ICM;
            T_HOLD: code = RLY_ICM;
            default: code = (want_x[i] && slow) ?
                            RLY_RING : RLY_ICM;
         endcase
         // first terminals: released relays put them on their own line
         if (i == 0 || i == 3) begin
            code = night_service ? 2'h0 :
                   first_sense(code, i == 3);
         end
         s_next.ra[i] = code[1];
         s_next.rb[i] = code[0];
         for (int l = 0; l < NL; l++) begin
            if (ring_act[l]) begin
               s_next.lamp[i*2+l] = slow;
            end else if (s_reg.hold[l] && s_reg.hdr[l] == i &&
                         (s_reg.ts[i] == T_HOLD ||
                          s_reg.ts[i] == T_RBACK)) begin
               s_next.lamp[i*2+l] = fast;
            end else begin
               s_next.lamp[i*2+l] = line_loop_detect[l];
            end
         end
      end
   end

   // reset puts every terminal idle with all relays released, so the first terminals sit on their own line
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // one 13-bit command word per decoder: hold, relay pairs, lamps
   always_comb begin
      frame = '0;
      for (int d = 0; d < NL; d++) begin
         frame[d*DEC_BITS+12] = s_reg.hold[d];
         for (int j = 0; j < 3; j++) begin
            frame[d*DEC_BITS+11-2*j] = s_reg.ra[3*d+j];
            frame[d*DEC_BITS+10-2*j] = s_reg.rb[3*d+j];
            frame[d*DEC_BITS+5-2*j]  = s_reg.lamp[(3*d+j)*2];
            frame[d*DEC_BITS+4-2*j]  = s_reg.lamp[(3*d+j)*2+1];
         end
      end
   end

   ksc_ser u_ser (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .frame     (frame),
      .dec_data  (dec_data),
      .dec_clk   (dec_clk),
      .dec_latch (dec_latch)
   );

   assign scan_select     = s_reg.si;
   assign relay_select_a  = s_reg.ra;
   assign relay_select_b  = s_reg.rb;
   assign line_hold_relay = s_reg.hold;
   assign line_lamp       = s_reg.lamp;

   localparam int SCAN_W = 520;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_hold_req;
      press && is_line && !s_reg.fa[t] && s_reg.ts[t] == T_EXCH &&
      s_reg.tl[t] == bl && line_loop_detect[bl];
   endsequence
   sequence s_rel_done;
      scan_en && t == 3'h1 && s_reg.ts[1] == T_REL && !lp &&
      s_reg.tc[1] >= REL_TICKS && !want_x[1];
   endsequence

   property p_night;
      night_service |=> !relay_select_a[0] && !relay_select_b[0] &&
                        !relay_select_a[3] && !relay_select_b[3];
   endproperty
   a_night: assert property (p_night)
      else $error("first terminal relays energised at night");

   property p_lamp_off;
      !line_loop_detect[0] && !ring_act[0] && !s_reg.hold[0]
      |=> (line_lamp & 12'h555) == 12'h000;
   endproperty
   a_lamp_off: assert property (p_lamp_off)
      else $error("line lamp lit with line loop clear");

   property p_ring_stop;
      scan_en && s_reg.ts[t] == T_RINGI && lp && !press
      |=> s_reg.ts[$past(t)] == T_IDLE;
   endproperty
   a_ring_stop: assert property (p_ring_stop)
      else $error("ringing not stopped on answer");

   property p_release;
      s_rel_done |=> s_reg.ts[1] == T_IDLE ##1
                     !relay_select_a[1] && !relay_select_b[1];
   endproperty
   a_release: assert property (p_release)
      else $error("relays not back to intercom after delay");

   property p_hold;
      s_hold_req |=> line_hold_relay[$past(bl)] &&
                     s_reg.ts[$past(t)] == T_HOLD;
   endproperty
   a_hold: assert property (p_hold)
      else $error("hold not taken on line button");

   property p_unhold;
      $rose(s_reg.relp[0]) |-> ##[1:SCAN_W] !line_hold_relay[0];
   endproperty
   a_unhold: assert property (p_unhold)
      else $error("hold relay not released after reconnect");

   property p_cadence;
      s_reg.ts[1] == T_RINGI && !scan_en
      |=> relay_select_a[1] == $past(slow) && !relay_select_b[1];
   endproperty
   a_cadence: assert property (p_cadence)
      else $error("intercom ringing cadence wrong");

   property p_hold_flash;
      s_reg.hold[0] && s_reg.hdr[0] == 3'h1 && s_reg.ts[1] == T_HOLD &&
      !ring_act[0] |=> line_lamp[2] == $past(fast);
   endproperty
   a_hold_flash: assert property (p_hold_flash)
      else $error("holding lamp not flashing");

   property p_ring_flash;
      ring_act[0] |=> line_lamp[0] == $past(slow) &&
                      line_lamp[2] == $past(slow);
   endproperty
   a_ring_flash: assert property (p_ring_flash)
      else $error("incoming line lamps not flashing");

   property p_tick;
      s_reg.tick |=> !s_reg.tick [*2];
   endproperty
   a_tick: assert property (p_tick)
      else $error("cadence tick not a single pulse");
endmodule : ksc_call_ctrl
`default_nettype wire

//--- design/ksc_ser.sv
`timescale 1ns/100ps
`default_nettype none
module ksc_ser (
   input  wire logic                           clk_sys,
   input  wire logic                           rst,
   input  wire logic [ksc_pkg::FRAME_BITS-1:0] frame,
   output logic                                dec_data,
   output logic                                dec_clk,
   output logic                                dec_latch
);
   import ksc_pkg::*;

   typedef struct packed {
      logic [FRAME_BITS-1:0] sh;
      logic [FB_W-1:0]       bits;
      logic [2:0]            cyc;
      logic                  data;
      logic                  clk;
      logic                  latch;
   } ksc_ser_t;

   ksc_ser_t s_reg, s_next;

   // one bit per SER_CYC cycles, msb first; each bit is set up five cycles
   // before its clock pulse, in the same slot; a latch pulse closes each frame so
   // the decoders never show a half-shifted command word
   always_comb begin
      s_next = s_reg;
      s_next.clk = 1'b0;
      s_next.latch = 1'b0;
      s_next.cyc = s_reg.cyc + 3'h1;
      if (s_reg.cyc == SER_MID && s_reg.bits != '0) begin
         s_next.clk = 1'b1;
      end
      if (s_reg.cyc == SER_LAST) begin
         if (s_reg.bits == '0) begin
            s_next.data = frame[FRAME_BITS-1];
            s_next.sh   = {frame[FRAME_BITS-2:0], 1'b0};
            s_next.bits = FB_W'(FRAME_BITS);
         end else if (s_reg.bits == FB_W'(1)) begin
            s_next.bits  = '0;
            s_next.latch = 1'b1;
         end else begin
            s_next.data = s_reg.sh[FRAME_BITS-1];
            s_next.sh   = {s_reg.sh[FRAME_BITS-2:0], 1'b0};
            s_next.bits = s_reg.bits - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign dec_data  = s_reg.data;
   assign dec_clk   = s_reg.clk;
   assign dec_latch = s_reg.latch;

   property p_latch_gap;
      @(posedge clk_sys) disable iff (rst)
      dec_latch |=> !dec_latch [*7];
   endproperty
   a_latch_gap: assert property (p_latch_gap)
      else $error("latch pulses too close");
endmodule : ksc_ser
`default_nettype wire

//--- include/ksc_pkg.sv
`default_nettype none
package ksc_pkg;
   localparam int NT        = 6;
   localparam int NL        = 2;
   localparam int CLK_HZ    = 200_000_000;
   localparam int TICK_MS   = 10;
   localparam int TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
   localparam int DIV_W     = 21;
   localparam int SCAN_CYC  = 500;
   localparam int SC_W      = 10;
   localparam int TC_W      = 8;
   // release delay, ringing cadences and ring-back delay in ms
   localparam int REL_MS    = 750;
   localparam int RING_MS   = 2000;
   localparam int FAST_MS   = 1000;
   localparam int RB_MS     = 500;
   localparam logic [TC_W-1:0] REL_TICKS = TC_W'(REL_MS / TICK_MS);
   localparam logic [TC_W-1:0] RING_HALF = TC_W'(RING_MS / 2 / TICK_MS);
   localparam logic [TC_W-1:0] FAST_HALF = TC_W'(FAST_MS / 2 / TICK_MS);
   localparam logic [TC_W-1:0] RB_TICKS  = TC_W'(RB_MS / TICK_MS);
   localparam logic [2:0] LAST_TERM = 3'h5;
   localparam logic [SC_W-1:0] SCAN_LAST = SC_W'(SCAN_CYC - 1);
   // button codes from the comparator
   localparam logic [3:0] BTN_NONE  = 4'h0;
   localparam logic [3:0] BTN_EXT1  = 4'h1;
   localparam logic [3:0] BTN_EXT2  = 4'h2;
   localparam logic [3:0] BTN_EXT6  = 4'h6;
   localparam logic [3:0] BTN_LINE1 = 4'h8;
   localparam logic [3:0] BTN_LINE2 = 4'h9;
   localparam logic [3:0] BTN_FAC   = 4'hF;
   // relay pair codes {a,b}
   localparam logic [1:0] RLY_ICM   = 2'h0;
   localparam logic [1:0] RLY_L1    = 2'h1;
   localparam logic [1:0] RLY_RING  = 2'h2;
   localparam logic [1:0] RLY_L2    = 2'h3;
   // serial command stream to the decoders
   localparam int DEC_BITS   = 13;
   localparam int FRAME_BITS = 26;
   localparam int FB_W       = 5;
   localparam int SER_CYC    = 8;
   localparam logic [2:0] SER_LAST = 3'h7;
   localparam logic [2:0] SER_MID  = 3'h4;
   typedef enum logic [2:0] {
      T_IDLE  = 3'b000,
      T_RINGI = 3'b001,
      T_EXCH  = 3'b010,
      T_REL   = 3'b011,
      T_HOLD  = 3'b100,
      T_RBACK = 3'b101
   } ksc_term_t;
endpackage : ksc_pkg
`default_nettype wire

//--- verif/key_system_call_controller_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR %s exp %0h got %0h", n, e, g); end end
module key_system_call_controller_tb;
   import ksc_pkg::*;
   logic clk_sys = 0, rst = 1, night_service = 0;
   logic [5:0] loop = 0, ra, rb;
   logic [1:0] ring = 0, eloop, hold;
   logic [23:0] btn = 0;
   logic [3:0] code;
   logic [2:0] scan;
   logic [11:0] lamp;
   logic dd, dk, dl;
   logic [25:0] ssh, cap;
   int n_errors = 0, n_tests = 0, tog;
   ksc_call_ctrl #(.TICK_CYC_P(20)) dut (.clk_sys(clk_sys), .rst(rst),
      .terminal_loop_detect(loop), .line_ring_detect(ring),
      .line_loop_detect(eloop), .button_code(code),
      .night_service(night_service), .scan_select(scan),
      .relay_select_a(ra), .relay_select_b(rb), .line_hold_relay(hold),
      .line_lamp(lamp), .dec_data(dd), .dec_clk(dk), .dec_latch(dl));
   ksc_far far (.scan_select(scan), .relay_select_a(ra),
      .relay_select_b(rb), .line_hold_relay(hold),
      .terminal_loop_detect(loop), .btn(btn), .button_code(code),
      .line_loop_detect(eloop));
   initial forever #2.5 clk_sys = ~clk_sys;
   // decoder side: shift on each clock pulse, take the word on latch
   always @(negedge clk_sys) begin
      if (dk) ssh <= {ssh[24:0], dd};
      if (dl) cap <= ssh;
   end
   // relay pair as a code; first of a group: released is its own line
   function automatic logic [1:0] pr(input int t);
      logic [1:0] o, own;
      o = {ra[t], rb[t]};
      own = (t == 0) ? RLY_L1 : RLY_L2;
      if (t % 3 != 0) pr = o;
      else if (o == 2'h0) pr = own;
      else if (o == ~own) pr = RLY_L2;
      else pr = ~o;
   endfunction : pr
   task automatic results();
      if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   task automatic wait_pr(input int t, input logic [1:0] v, input int lim);
      int i;
      for (i = 0; i < lim && pr(t) !== v; i++) @(negedge clk_sys);
      `CHK("relay pair", v, pr(t))
      if (pr(t) !== v) results();
   endtask : wait_pr
   // caller is off-hook first; code held over a full scan round, then 0
   task automatic press(input int t, input logic [3:0] c);
      btn[4*t +: 4] = c;
      repeat (3100) @(negedge clk_sys);
      btn[4*t +: 4] = 4'h0;
      repeat (3100) @(negedge clk_sys);
   endtask : press
   // count lamp toggles over a stretch
   task automatic count_tog(input int b, input int n);
      logic l;
      tog = 0;
      l = lamp[b];
      repeat (n) begin
         @(negedge clk_sys);
         if (lamp[b] !== l) tog++;
         l = lamp[b];
      end
   endtask : count_tog
   task automatic t_reset();
      `CHK("reset relays", 12'h000, {ra, rb})
      @(negedge clk_sys) rst = 0;
      repeat (3) @(negedge clk_sys);
      `CHK("idle pair t0", 2'h0, pr(0))
      `CHK("idle lamps", 12'h000, lamp)
   endtask : t_reset
   task automatic t_outgoing();
      loop[1] = 1;
      press(1, BTN_LINE1);
      wait_pr(1, RLY_L1, 10);
      `CHK("line lamps", 6'h3F, {lamp[10], lamp[8], lamp[6], lamp[4],
         lamp[2], lamp[0]})
      loop[1] = 0;
      repeat (1000) @(negedge clk_sys);
      `CHK("flash keeps line", RLY_L1, pr(1))
      wait_pr(1, RLY_ICM, 6500);
      repeat (3) @(negedge clk_sys);
      `CHK("lamps out", 1'b0, lamp[4])
   endtask : t_outgoing
   task automatic t_hold();
      loop[1] = 1;
      press(1, BTN_LINE1);
      press(1, BTN_LINE1);
      `CHK("hold on", 2'h1, hold)
      `CHK("holder intercom", RLY_ICM, pr(1))
      `CHK("serial frame", 6'h1C, {cap[25], cap[12:8]})
      count_tog(2, 2100);
      `CHK("holder flashes", 1'b1, tog > 0)
      count_tog(0, 2100);
      `CHK("other lamp steady", 0, tog)
      `CHK("others steady", 1'b1, lamp[0] & lamp[8])
      press(1, BTN_LINE1);
      `CHK("reconnect", RLY_L1, pr(1))
      `CHK("hold off", 2'h0, hold)
      loop[1] = 0;
      wait_pr(1, RLY_ICM, 6500);
   endtask : t_hold
   task automatic t_intercom();
      loop[2] = 1;
      btn[8 +: 4] = 4'h2;
      // sync to a phase start before timing a ringing half period
      wait_pr(1, RLY_RING, 5200);
      wait_pr(1, RLY_ICM, 2100);
      wait_pr(1, RLY_RING, 2100);
      repeat (1900) @(negedge clk_sys);
      `CHK("ring half", RLY_RING, pr(1))
      wait_pr(1, RLY_ICM, 300);
      btn[8 +: 4] = 4'h0;
      loop[1] = 1;
      repeat (3100) @(negedge clk_sys);
      `CHK("answered", RLY_ICM, pr(1))
      repeat (4100) @(negedge clk_sys);
      `CHK("no more ring", RLY_ICM, pr(1))
      loop = 0;
   endtask : t_intercom
   task automatic t_night();
      night_service = 1;
      repeat (3) @(negedge clk_sys);
      `CHK("night t0 t3", 4'h0, {ra[0], rb[0], ra[3], rb[3]})
      night_service = 0;
      repeat (3) @(negedge clk_sys);
   endtask : t_night
   task automatic t_incoming();
      loop[4] = 1;
      press(4, BTN_FAC);
      press(4, BTN_LINE1);
      `CHK("prog no call", RLY_ICM, pr(4))
      loop[4] = 0;
      ring[0] = 1;
      wait_pr(4, RLY_RING, 4100);
      count_tog(6, 4500);
      `CHK("incoming flash", 1'b1, tog > 0)
      loop[2] = 1;
      press(2, BTN_LINE1);
      wait_pr(2, RLY_L1, 10);
      count_tog(6, 2500);
      `CHK("steady lamps", 0, tog)
      ring[0] = 0;
      loop[2] = 0;
      wait_pr(2, RLY_ICM, 6500);
   endtask : t_incoming
   initial begin
      repeat (12) @(negedge clk_sys);
      t_reset();
      t_night();
      t_outgoing();
      t_hold();
      t_intercom();
      t_incoming();
      results();
   end
endmodule : key_system_call_controller_tb
`default_nettype wire

//--- verif/ksc_far.sv
`timescale 1ns/100ps
`default_nettype none
// far side: comparator mux and exchange line loop current
module ksc_far (
   input  wire logic [2:0]  scan_select,
   input  wire logic [5:0]  relay_select_a,
   input  wire logic [5:0]  relay_select_b,
   input  wire logic [1:0]  line_hold_relay,
   input  wire logic [5:0]  terminal_loop_detect,
   input  wire logic [23:0] btn,
   output logic      [3:0]  button_code,
   output logic      [1:0]  line_loop_detect
);
   logic [1:0] pair;
   logic [1:0] own;
   // only the scanned terminal reaches the comparator
   assign button_code = btn[4*scan_select +: 4];
   // held line or an off-hook terminal on the line closes the loop; the
   // first of a group sits on intercom with both relays energised and on
   // its own line with both released
   always_comb begin
      line_loop_detect = line_hold_relay;
      pair = 2'h0;
      own = 2'h0;
      for (int t = 0; t < 6; t++) begin
         pair = {relay_select_a[t], relay_select_b[t]};
         own = (t == 0) ? 2'h1 : 2'h3;
         if (t % 3 == 0) begin
            if (pair == 2'h0) pair = own;
            else if (pair == ~own) pair = 2'h3;
            else pair = ~pair;
         end
         if (terminal_loop_detect[t] && pair == 2'h1) begin
            line_loop_detect[0] = 1'b1;
         end
         if (terminal_loop_detect[t] && pair == 2'h3) begin
            line_loop_detect[1] = 1'b1;
         end
      end
   end
endmodule : ksc_far
`default_nettype wire
